// [hw/mscc_pkg.sv]
package mscc_pkg;

  // ==========================================================
  // Encoder modes and fieldbus state
  typedef enum logic [1:0] {
    MODE_INCREMENTAL,
    MODE_ABS_LINEAR,
    MODE_SINGLE_TURN,
    MODE_ROTATION
  } mscc_mode_type;

  localparam logic [3:0] ESM_OP = 4'h8;

  // ==========================================================
  // Numeric bounds
  localparam logic signed [31:0] POS_MAX = 32'h7FFF_FFFF;
  localparam logic signed [31:0] POS_MIN = 32'h8000_0000;
  localparam logic [7:0] MAP_MAX = 8'h0A;
  // Gear window: 1/1000 < num/den < 4000 * res / 10000
  localparam logic [15:0] GEAR_MIN_INV = 16'h03E8;
  localparam logic [15:0] GEAR_MAX_MUL = 16'h0FA0;
  localparam logic [15:0] GEAR_RES_DIV = 16'h2710;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SYNC_TIMEOUT_US = 1000;
  localparam int unsigned SYNC_TIMEOUT_CYC_DEF = SYNC_TIMEOUT_US * 1000 / CLK_PERIOD_NS;

  // ==========================================================
  // Fault codes, one per check
  localparam logic [15:0] CODE_NONE = 16'h0000;
  localparam logic [15:0] CODE_CMD_OVF = 16'h0001;
  localparam logic [15:0] CODE_ST_TARGET = 16'h0002;
  localparam logic [15:0] CODE_SOFT_LIM = 16'h0003;
  localparam logic [15:0] CODE_HOME = 16'h0004;
  localparam logic [15:0] CODE_GEAR = 16'h0005;
  localparam logic [15:0] CODE_SYNC = 16'h0006;
  localparam logic [15:0] CODE_MAP = 16'h0007;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic command_overflow_fault;
    logic single_turn_target_fault;
    logic soft_limit_setting_fault;
    logic home_setting_fault;
    logic gear_ratio_fault;
    logic missing_sync_fault;
    logic mapping_overflow_fault;
  } mscc_fault_type;

  localparam mscc_fault_type FAULT_RESET = 7'h00;

  typedef struct packed {
    mscc_mode_type mode;
    logic signed [31:0] soft_lo;
    logic signed [31:0] soft_hi;
    logic signed [31:0] home_ofs;
    logic signed [31:0] unit_lo;
    logic signed [31:0] unit_hi;
    logic signed [31:0] mech_lo;
    logic signed [31:0] mech_hi;
    logic [31:0] gear_num;
    logic [31:0] gear_den;
    logic [31:0] enc_res;
    logic [7:0] tx_map_cnt;
    logic [7:0] rx_map_cnt;
  } mscc_cfg_type;

endpackage

// [hw/mscc_sync_watch.sv]
`timescale 1ns/10ps
module mscc_sync_watch #(
  parameter int unsigned TIMEOUT_CYC = 100000
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] esm_state,
  input wire logic sync_pulse,
  output logic fault_pulse
);
  import mscc_pkg::*;

  // ==========================================================
  // Watchdog armed on each entry into operational
  typedef enum logic [1:0] {SW_IDLE, SW_WAIT, SW_DONE} mscc_sw_type;

  mscc_sw_type state_r, state_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic in_op_r, in_op_nxt;
  logic fault_r, fault_nxt;
  logic in_op;

  assign in_op = (esm_state == ESM_OP);
  assign fault_pulse = fault_r;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    in_op_nxt = in_op;
    fault_nxt = 1'b0;
    unique case (state_r)
      SW_IDLE: begin
        if (in_op && !in_op_r) begin
          state_nxt = SW_WAIT;
          cnt_nxt = 32'h0000_0000;
        end
      end
      SW_WAIT: begin
        if (!in_op) begin
          state_nxt = SW_IDLE;
        end else if (sync_pulse) begin
          state_nxt = SW_DONE;
        end else if (cnt_r == TIMEOUT_CYC - 1) begin
          fault_nxt = 1'b1;
          state_nxt = SW_DONE;
        end else begin
          cnt_nxt = cnt_r + 32'h0000_0001;
        end
      end
      SW_DONE: begin
        // Re-armed only after leaving operational
        if (!in_op) begin
          state_nxt = SW_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= SW_IDLE;
      cnt_r <= 32'h0000_0000;
      in_op_r <= 1'b0;
      fault_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      in_op_r <= in_op_nxt;
      fault_r <= fault_nxt;
    end
  end

  // ==========================================================
  // Checks
  sequence s_enter_op;
    in_op && !in_op_r && state_r == SW_IDLE;
  endsequence

  chk_sync_arm: assert property (@(posedge clk) disable iff (!nrst)
    s_enter_op |=> state_r == SW_WAIT && cnt_r == 32'h0000_0000)
    else $error("watchdog not armed on entry to operational");

  chk_sync_cause: assert property (@(posedge clk) disable iff (!nrst)
    fault_r |-> $past(state_r == SW_WAIT && in_op && !sync_pulse
                      && cnt_r == TIMEOUT_CYC - 1))
    else $error("sync fault without full timeout");

endmodule

// [hw/mscc_checker.sv]
`timescale 1ns/10ps
module mscc_checker #(
  parameter int unsigned SYNC_TIMEOUT_CYC = mscc_pkg::SYNC_TIMEOUT_CYC_DEF
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic SP_VALID,
  input wire logic signed [31:0] SP_TARGET,
  input wire logic signed [31:0] POS_ACC,
  input wire logic LIMIT_HW,
  input wire logic LIMIT_SW,
  input wire mscc_pkg::mscc_cfg_type CFG,
  input wire logic [3:0] ESM_STATE,
  input wire logic SYNC_PULSE,
  input wire mscc_pkg::mscc_fault_type FAULT_CLR,
  output mscc_pkg::mscc_fault_type FAULTS,
  output logic [15:0] FAULT_CODE,
  output logic FAULT_ANY
);
  import mscc_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic outside(input logic signed [31:0] v,
                                   input logic signed [31:0] lo,
                                   input logic signed [31:0] hi);
    outside = (v < lo) || (v > hi);
  endfunction

  // Wide products so no ratio is ever rounded
  function automatic logic gear_bad(input logic [31:0] num,
                                    input logic [31:0] den,
                                    input logic [31:0] res);
    logic [79:0] lo_lhs;
    logic [79:0] hi_lhs;
    logic [79:0] hi_rhs;
    lo_lhs = 80'(num) * 80'(GEAR_MIN_INV);
    hi_lhs = 80'(num) * 80'(GEAR_RES_DIV);
    hi_rhs = 80'(GEAR_MAX_MUL) * 80'(res) * 80'(den);
    gear_bad = !(lo_lhs > 80'(den)) || !(hi_lhs < hi_rhs);
  endfunction

  // First-declared field (the MSB) wins when several faults are latched
  function automatic logic [15:0] code_of(input mscc_fault_type f);
    if (f.command_overflow_fault) code_of = CODE_CMD_OVF;
    else if (f.single_turn_target_fault) code_of = CODE_ST_TARGET;
    else if (f.soft_limit_setting_fault) code_of = CODE_SOFT_LIM;
    else if (f.home_setting_fault) code_of = CODE_HOME;
    else if (f.gear_ratio_fault) code_of = CODE_GEAR;
    else if (f.missing_sync_fault) code_of = CODE_SYNC;
    else if (f.mapping_overflow_fault) code_of = CODE_MAP;
    else code_of = CODE_NONE;
  endfunction

  // ==========================================================
  // Sync watchdog
  logic sync_fault;

  mscc_sync_watch #(
    .TIMEOUT_CYC(SYNC_TIMEOUT_CYC)
  ) u_sync (
    .clk(CLK),
    .nrst(NRST),
    .esm_state(ESM_STATE),
    .sync_pulse(SYNC_PULSE),
    .fault_pulse(sync_fault)
  );

  // ==========================================================
  // Detection
  mscc_fault_type det;
  logic at_bound;
  logic lin_mode;

  always_comb begin
    at_bound = (POS_ACC == POS_MAX) || (POS_ACC == POS_MIN);
    lin_mode = (CFG.mode == MODE_INCREMENTAL) || (CFG.mode == MODE_ABS_LINEAR)
               || (CFG.mode == MODE_SINGLE_TURN);
    det = FAULT_RESET;
    det.command_overflow_fault = SP_VALID && (LIMIT_HW || LIMIT_SW) && at_bound;
    det.single_turn_target_fault = SP_VALID && (CFG.mode == MODE_SINGLE_TURN)
                                   && outside(SP_TARGET, CFG.unit_lo, CFG.unit_hi);
    det.soft_limit_setting_fault = (CFG.soft_lo >= CFG.soft_hi);
    det.home_setting_fault =
      (lin_mode && outside(CFG.home_ofs, CFG.soft_lo, CFG.soft_hi))
      || ((CFG.mode == MODE_ROTATION)
          && outside(CFG.home_ofs, CFG.mech_lo, CFG.mech_hi));
    det.gear_ratio_fault = gear_bad(CFG.gear_num, CFG.gear_den, CFG.enc_res);
    det.missing_sync_fault = sync_fault;
    det.mapping_overflow_fault = (CFG.tx_map_cnt > MAP_MAX)
                                 || (CFG.rx_map_cnt > MAP_MAX);
  end

  // ==========================================================
  // Latch; a new detection beats a clear in the same cycle
  mscc_fault_type faults_r, faults_nxt;
  logic [15:0] code_r, code_nxt;
  logic any_r, any_nxt;

  always_comb begin
    faults_nxt = (faults_r & ~FAULT_CLR) | det;
    code_nxt = code_of(faults_nxt);
    any_nxt = |faults_nxt;
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      faults_r <= FAULT_RESET;
      code_r <= CODE_NONE;
      any_r <= 1'b0;
    end else begin
      faults_r <= faults_nxt;
      code_r <= code_nxt;
      any_r <= any_nxt;
    end
  end

  assign FAULTS = faults_r;
  assign FAULT_CODE = code_r;
  assign FAULT_ANY = any_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  chk_cmd_overflow: assert property (
    SP_VALID && LIMIT_HW && POS_ACC == POS_MAX |=> FAULTS.command_overflow_fault)
    else $error("overflow at bound not latched");

  chk_ovf_cause: assert property (
    $rose(FAULTS.command_overflow_fault) |-> $past(SP_VALID && (LIMIT_HW || LIMIT_SW)))
    else $error("overflow fault without setpoint at limit");

  chk_st_target: assert property (
    SP_VALID && CFG.mode == MODE_SINGLE_TURN && SP_TARGET > CFG.unit_hi
    |=> FAULTS.single_turn_target_fault && FAULT_ANY)
    else $error("single-turn target above bound not flagged");

  chk_soft_order: assert property (
    $rose(FAULTS.soft_limit_setting_fault) |-> $past(CFG.soft_lo >= CFG.soft_hi))
    else $error("soft limit fault raised with valid order");

  chk_home_linear: assert property (
    CFG.mode == MODE_ABS_LINEAR && CFG.home_ofs < CFG.soft_lo |=> FAULTS.home_setting_fault)
    else $error("home below soft limit not flagged");

  chk_home_rotation: assert property (
    CFG.mode == MODE_ROTATION && CFG.home_ofs > CFG.mech_hi |=> FAULTS.home_setting_fault)
    else $error("home beyond mechanical bound not flagged");

  chk_gear_zero: assert property (
    CFG.gear_num == 32'h0000_0000 |=> FAULTS.gear_ratio_fault)
    else $error("zero gear ratio not flagged");

  chk_map_count: assert property (
    CFG.rx_map_cnt == 8'h0B |=> FAULTS.mapping_overflow_fault)
    else $error("eleven mapped objects not flagged");

  chk_sync_latch: assert property (
    sync_fault |=> FAULTS.missing_sync_fault ##0 FAULT_CODE != CODE_NONE)
    else $error("sync timeout not latched");

  chk_fault_hold: assert property (
    FAULTS.gear_ratio_fault && !FAULT_CLR.gear_ratio_fault |=> FAULTS.gear_ratio_fault)
    else $error("latched fault dropped without clear");

  chk_code_match: assert property (
    FAULTS.command_overflow_fault |-> FAULT_CODE == CODE_CMD_OVF && FAULT_ANY)
    else $error("fault code does not match top fault");

  // ==========================================================
  // Checks: further detection cases
  sequence s_soft_bad;
    CFG.soft_lo >= CFG.soft_hi;
  endsequence

  chk_ovf_low: assert property (
    SP_VALID && LIMIT_SW && POS_ACC == POS_MIN |=> FAULTS.command_overflow_fault)
    else $error("overflow at lower bound not latched");

  chk_ovf_bound: assert property (
    $rose(FAULTS.command_overflow_fault) |-> $past(POS_ACC == POS_MAX || POS_ACC == POS_MIN))
    else $error("overflow fault away from a bound");

  chk_st_below: assert property (
    SP_VALID && CFG.mode == MODE_SINGLE_TURN && SP_TARGET < CFG.unit_lo
    |=> FAULTS.single_turn_target_fault)
    else $error("single-turn target below bound not flagged");

  chk_st_mode: assert property (
    $rose(FAULTS.single_turn_target_fault) |-> $past(SP_VALID && CFG.mode == MODE_SINGLE_TURN))
    else $error("target fault outside single-turn mode");

  chk_soft_flag: assert property (
    s_soft_bad |=> FAULTS.soft_limit_setting_fault)
    else $error("inverted soft limits not flagged");

  chk_home_incr: assert property (
    CFG.mode == MODE_INCREMENTAL && CFG.home_ofs > CFG.soft_hi |=> FAULTS.home_setting_fault)
    else $error("home above soft limit not flagged");

  chk_gear_den: assert property (
    CFG.gear_den == 32'h0000_0000 |=> FAULTS.gear_ratio_fault)
    else $error("zero gear denominator not flagged");

  chk_map_tx: assert property (
    CFG.tx_map_cnt > MAP_MAX |=> FAULTS.mapping_overflow_fault)
    else $error("transmit mapping overflow not flagged");

  chk_map_cause: assert property (
    $rose(FAULTS.mapping_overflow_fault)
    |-> $past(CFG.tx_map_cnt > MAP_MAX || CFG.rx_map_cnt > MAP_MAX))
    else $error("mapping fault with legal counts");

  chk_code_sync: assert property (
    FAULTS == 7'h02 |-> FAULT_CODE == CODE_SYNC && FAULT_ANY)
    else $error("sync fault code wrong");

  // ==========================================================
  // Checks: clear path
  // A clear only sticks once the cause is gone; set wins otherwise
  sequence s_ovf_clear_req;
    FAULTS.command_overflow_fault && FAULT_CLR.command_overflow_fault;
  endsequence

  sequence s_ovf_gone;
    !(SP_VALID && (LIMIT_HW || LIMIT_SW) && at_bound);
  endsequence

  chk_clear_drop: assert property (
    s_ovf_clear_req ##0 s_ovf_gone |=> !FAULTS.command_overflow_fault)
    else $error("cleared overflow fault still latched");

  chk_set_wins: assert property (
    s_soft_bad ##0 FAULT_CLR.soft_limit_setting_fault |=> FAULTS.soft_limit_setting_fault)
    else $error("clear beat a persisting fault");

endmodule

// [tb/mscc_host_model.sv]
`timescale 1ns/10ps
// ==========================================================
// Host motion controller: streams setpoints, backs off at limits
module mscc_host_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0] limit_bits,
  input wire logic go,
  input wire logic obey,
  input wire logic signed [31:0] tgt,
  output logic sp_valid,
  output logic signed [31:0] sp_target
);
  // Limit bits 0 and 1 watched; obey low in both overflow tests and the no-limit saturation test
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sp_valid <= 1'b0;
      sp_target <= 32'h0000_0000;
    end else begin
      sp_valid <= go & ~(obey & (|limit_bits));
      // Idle data inverts so a stale target never looks valid
      sp_target <= go ? tgt : ~sp_target;
    end
  end
endmodule

// [tb/mscc_checker_tb_top.sv]
`timescale 1ns/10ps
module mscc_checker_tb_top;
  import mscc_pkg::*;
  localparam int unsigned T = 8;
  logic clk, nrst, go, obey, lim_hw, lim_sw, sp_valid, sync_pulse, any;
  logic signed [31:0] tgt, sp_target, pos_acc;
  logic [3:0] esm;
  logic [15:0] code;
  mscc_cfg_type cfg, good;
  mscc_fault_type clr, faults;
  int err_count, num_checks, cycles;

  mscc_host_model i_mscc_host_model (.clk(clk), .nrst(nrst), .limit_bits({lim_sw, lim_hw}),
    .go(go), .obey(obey), .tgt(tgt), .sp_valid(sp_valid), .sp_target(sp_target));
  mscc_checker #(.SYNC_TIMEOUT_CYC(T)) i_mscc_checker (.CLK(clk), .NRST(nrst),
    .SP_VALID(sp_valid), .SP_TARGET(sp_target), .POS_ACC(pos_acc), .LIMIT_HW(lim_hw),
    .LIMIT_SW(lim_sw), .CFG(cfg), .ESM_STATE(esm), .SYNC_PULSE(sync_pulse),
    .FAULT_CLR(clr), .FAULTS(faults), .FAULT_CODE(code), .FAULT_ANY(any));

  // ==========================================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      results();
    end
  end

  // ==========================================================
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic expect_state(input logic [15:0] exp_code, input logic [6:0] exp_bits);
    cyc(2);
    chk("FAULT_CODE", code, exp_code);
    chk("FAULTS", {9'h000, faults}, {9'h000, exp_bits});
    chk("FAULT_ANY", {15'h0000, any}, {15'h0000, |exp_bits});
  endtask
  // Clear held two cycles: the registered setpoint lags the stop by one
  task automatic restore_and_clear();
    cfg = good;
    go = 1'b0;
    lim_hw = 1'b0;
    lim_sw = 1'b0;
    pos_acc = 32'h0000_0000;
    clr = 7'h7f;
    cyc(2);
    clr = 7'h00;
    expect_state(CODE_NONE, 7'h00);
  endtask
  task automatic results();
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    good = '{MODE_INCREMENTAL, -32'sd1000, 32'sd1000, 32'sd0, 32'sd0, 32'sd1000, 32'sd0,
      32'sd1000, 32'd1, 32'd1, 32'd10000, 8'h02, 8'h02};
    cfg = good;
    {nrst, go, obey, lim_hw, lim_sw, sync_pulse} = 6'b000000;
    {tgt, pos_acc, esm, clr, cycles, err_count, num_checks} = '0;
    cyc(20);
    nrst = 1'b1;
    expect_state(CODE_NONE, 7'h00);
    // Host obeys the limit, so a saturated position is harmless
    {pos_acc, lim_hw, obey, go} = {POS_MAX, 3'b111};
    expect_state(CODE_NONE, 7'h00);
    obey = 1'b0;
    expect_state(CODE_CMD_OVF, 7'h40);
    restore_and_clear();
    {pos_acc, lim_sw, obey, go} = {POS_MIN, 3'b101};
    expect_state(CODE_CMD_OVF, 7'h40);
    // Mid-run reset drops a latched fault
    {nrst, go, lim_sw} = 3'b000;
    expect_state(CODE_NONE, 7'h00);
    nrst = 1'b1;
    expect_state(CODE_NONE, 7'h00);
    restore_and_clear();
    // Saturated position with no limit active stays quiet
    {pos_acc, go} = {POS_MAX, 1'b1};
    expect_state(CODE_NONE, 7'h00);
    restore_and_clear();
    {obey, go, tgt} = {2'b11, 32'sd5000};
    expect_state(CODE_NONE, 7'h00);
    restore_and_clear();
    cfg.mode = MODE_SINGLE_TURN;
    {go, tgt} = {1'b1, 32'sd1000};
    expect_state(CODE_NONE, 7'h00);
    tgt = 32'sd1001;
    expect_state(CODE_ST_TARGET, 7'h20);
    restore_and_clear();
    cfg.mode = MODE_SINGLE_TURN;
    {go, tgt} = {1'b1, -32'sd1};
    expect_state(CODE_ST_TARGET, 7'h20);
    restore_and_clear();
    // Empty soft range also puts the home offset outside it
    cfg.soft_lo = 32'sd1000;
    expect_state(CODE_SOFT_LIM, 7'h18);
    clr = 7'h7f;
    expect_state(CODE_SOFT_LIM, 7'h18);
    restore_and_clear();
    cfg.home_ofs = 32'sd1001;
    expect_state(CODE_HOME, 7'h08);
    restore_and_clear();
    cfg.mode = MODE_ABS_LINEAR;
    cfg.home_ofs = -32'sd500;
    expect_state(CODE_NONE, 7'h00);
    cfg.home_ofs = -32'sd1001;
    expect_state(CODE_HOME, 7'h08);
    restore_and_clear();
    cfg.mode = MODE_ROTATION;
    expect_state(CODE_NONE, 7'h00);
    cfg.home_ofs = -32'sd1;
    expect_state(CODE_HOME, 7'h08);
    restore_and_clear();
    cfg.mode = MODE_ROTATION;
    cfg.home_ofs = 32'sd1001;
    expect_state(CODE_HOME, 7'h08);
    restore_and_clear();
    {cfg.gear_num, cfg.gear_den} = {32'd1, 32'd1000};
    expect_state(CODE_GEAR, 7'h04);
    {cfg.gear_num, cfg.gear_den} = {32'd4000, 32'd1};
    expect_state(CODE_GEAR, 7'h04);
    restore_and_clear();
    {cfg.gear_num, cfg.gear_den} = {32'd0, 32'd0};
    expect_state(CODE_GEAR, 7'h04);
    restore_and_clear();
    cfg.gear_num = 32'd3999;
    expect_state(CODE_NONE, 7'h00);
    {cfg.gear_num, cfg.gear_den} = {32'd2, 32'd1000};
    expect_state(CODE_NONE, 7'h00);
    {cfg.tx_map_cnt, cfg.rx_map_cnt} = {8'h0a, 8'h0a};
    expect_state(CODE_NONE, 7'h00);
    cfg.rx_map_cnt = 8'h0b;
    expect_state(CODE_MAP, 7'h01);
    {cfg.tx_map_cnt, cfg.rx_map_cnt} = {8'h0b, 8'h02};
    cfg.home_ofs = 32'sd2000;
    expect_state(CODE_HOME, 7'h09);
    restore_and_clear();
    // Operational entry with no sync: watchdog fires T+1 edges after entry
    esm = ESM_OP;
    cyc(T + 1);
    chk("FAULT_CODE", code, CODE_NONE);
    cyc(1);
    chk("FAULT_CODE", code, CODE_SYNC);
    esm = 4'h4;
    restore_and_clear();
    esm = ESM_OP;
    cyc(3);
    sync_pulse = 1'b1;
    cyc(1);
    sync_pulse = 1'b0;
    expect_state(CODE_NONE, 7'h00);
    cyc(T);
    chk("FAULT_CODE", code, CODE_NONE);
    results();
  end
endmodule
